//--- hw/mph_pkg.sv
package mph_pkg;
   // timing
   localparam int CLK_HZ        = 25_000_000;
   localparam int CLK_NS        = 40;
   localparam int MIN_TRIG_NS   = 50;
   localparam int MIN_TRIG_CYC  = (MIN_TRIG_NS + CLK_NS - 1) / CLK_NS;
   localparam int BST_PULSE_NS  = 200;
   localparam int BST_PULSE_CYC = (BST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TOK_PULSE_NS  = 80;
   localparam int TOK_PULSE_CYC = (TOK_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SS_BASE_MS    = 1;
   localparam int SS_BASE_DEF   = CLK_HZ / 1000 * SS_BASE_MS;
   localparam int ROLE_WAIT     = 3;
   // command codes
   localparam logic [7:0] CODE_SS    = 8'h61;
   localparam logic [7:0] CODE_RAMP  = 8'hD0;
   localparam logic [7:0] CODE_DISCH = 8'hD1;
   localparam logic [7:0] CODE_MODE  = 8'hD2;
   localparam logic [7:0] CODE_VLIM  = 8'hD7;
   localparam logic [7:0] CODE_SHED  = 8'hE5;
   localparam logic [7:0] CODE_RRST  = 8'hEA;
   // register indices
   localparam int NREG     = 7;
   localparam int IX_SS    = 0;
   localparam int IX_RAMP  = 1;
   localparam int IX_DISCH = 2;
   localparam int IX_MODE  = 3;
   localparam int IX_VLIM  = 4;
   localparam int IX_SHED  = 5;
   localparam int IX_RRST  = 6;
   localparam logic [15:0] REG_RST = 16'h0000;
   // fields
   localparam int SS_CODE_LSB  = 0;
   localparam int RAMP_AMP_LSB = 1;
   localparam int DISCH_BIT    = 6;
   localparam int CCM_BIT      = 0;
   localparam int SHED_BIT     = 0;
   localparam int SHED_SRC_BIT = 1;
   localparam int RRST_BIT     = 3;
   // synchronised inputs
   localparam int SY_TOKEN = 0;
   localparam int SY_TRIG  = 1;
   localparam int SY_CROSS = 2;
   localparam int SY_SHED  = 3;
   localparam int SY_EN    = 4;
   localparam int SY_PG    = 5;
   localparam int SY_REF   = 6;
   localparam int SY_BST   = 7;
   localparam int SY_FBLOW = 8;
   localparam int SY_OV    = 9;
   localparam int SY_UV    = 10;
   localparam int SY_OT    = 11;
   localparam int SY_ZC    = 12;
   localparam int SY_N     = 13;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_PREBIAS = 3'b001,
      ST_SOFT    = 3'b011,
      ST_RUN     = 3'b010,
      ST_DISCH   = 3'b110
   } mph_state_e;
   typedef logic [15:0] mph_word_t;
endpackage

//--- hw/mph_phase_sequencer.sv
// Function
// R01: phase with token input high at power-up becomes master, others slaves.
// R02: master accepts reads and writes; slave accepts only writes.
// R03: master emits trigger on ramp crossing; only run-token phase acts.
// R04: firing phase turns high side on and pulses token output together.
// R05: falling edge on token input arms run token, awaiting next trigger.
// R06: high side turns off when the on-pulse width expires.
// R07: consecutive triggers spaced at least the minimum interval.
// R08: slave reports faults on power-good line; master watches that line.
// R09: master alone runs start-up, shutdown, and fires the first pulse; slaves here also shut down and discharge on their own disable.
// R10: only master applies ramp compensation, restarted per trigger or per modulation pulse.
// R11: three-bit field selects ramp amplitude.
// R12: ramp-reset bit 0 resets on modulation pulse, 1 on trigger.
// R13: mode bit 1 gives continuous conduction, 0 gives pulse skip.
// R14: shedding bit 0 enables slaves, 1 disables them.
// R15: with source bit set, slaves follow shedding pin level.
// R16: shedding never disables the master phase.
// R17: soft-start code selects 1, 2, 4, 8 or 16 ms; zero is 1 ms.
// R18: pre-biased start holds both switches off until reference exceeds feedback.
// R19: low bootstrap before that forces low side on about 200 ns.
// R20: disable with discharge latches switches off, discharges until feedback low.
// R21: one control bit enables output discharge.
// R22: valley current limit set by its own command register.
// R23: after firing, phase clears run token until next falling edge.
module mph_phase_sequencer #(
   parameter int SS_BASE_CYC = mph_pkg::SS_BASE_DEF
) (
   // clock and reset
   input  logic              clock,
   input  logic              rst,
   // token ring and trigger line
   input  logic              token_in,
   output logic              token_out,
   input  logic              trigger_in,
   output logic              trigger_out,
   // shared power-good alert line
   input  logic              pg_in,
   output logic              pg_out,
   output logic              pg_oe,
   // comparator and sense inputs
   input  logic              ramp_cross,
   input  logic              ref_above_fb,
   input  logic              bst_low,
   input  logic              fb_below_tenth,
   input  logic              zero_cross,
   input  logic              ov_fault,
   input  logic              uv_fault,
   input  logic              ot_fault,
   input  logic [7:0]        on_width,
   // enables
   input  logic              enable_pin,
   input  logic              op_on,
   input  logic              shedding_pin,
   // command port
   input  logic              cmd_valid,
   input  logic              cmd_write,
   input  logic [7:0]        cmd_code,
   input  mph_pkg::mph_word_t cmd_wdata,
   output logic              rsp_valid,
   output mph_pkg::mph_word_t rsp_data,
   output logic              rsp_nack,
   // power stage and loop controls
   output logic              high_side_switch,
   output logic              low_side_switch,
   output logic              discharge_switch,
   output logic              is_master,
   output logic              slave_fault,
   output logic              ramp_reset,
   output logic              ramp_active,
   output logic [2:0]        ramp_amp,
   output logic              ccm_mode,
   output mph_pkg::mph_word_t valley_limit
);
   import mph_pkg::*;

   function automatic logic [3:0] reg_idx(input logic [7:0] code);
      unique case (code)
         CODE_SS:    reg_idx = {1'b1, 3'(IX_SS)};
         CODE_RAMP:  reg_idx = {1'b1, 3'(IX_RAMP)};
         CODE_DISCH: reg_idx = {1'b1, 3'(IX_DISCH)};
         CODE_MODE:  reg_idx = {1'b1, 3'(IX_MODE)};
         CODE_VLIM:  reg_idx = {1'b1, 3'(IX_VLIM)};
         CODE_SHED:  reg_idx = {1'b1, 3'(IX_SHED)};
         CODE_RRST:  reg_idx = {1'b1, 3'(IX_RRST)};
         default:    reg_idx = 4'h0;
      endcase
   endfunction

   function automatic logic [19:0] ss_len(input logic [2:0] code);
      logic [19:0] base;
      base = 20'(SS_BASE_CYC);
      unique case (code)
         3'h0, 3'h1: ss_len = base;
         3'h2:       ss_len = base << 1;
         3'h3:       ss_len = base << 2;
         3'h4:       ss_len = base << 3;
         default:    ss_len = base << 4;
      endcase
   endfunction

   // input synchronisers
   logic [SY_N-1:0] raw;
   logic [SY_N-1:0] s1_q;
   logic [SY_N-1:0] s2_q;
   logic [SY_N-1:0] s3_q;
   assign raw[SY_TOKEN] = token_in;
   assign raw[SY_TRIG]  = trigger_in;
   assign raw[SY_CROSS] = ramp_cross;
   assign raw[SY_SHED]  = shedding_pin;
   assign raw[SY_EN]    = enable_pin;
   assign raw[SY_PG]    = pg_in;
   assign raw[SY_REF]   = ref_above_fb;
   assign raw[SY_BST]   = bst_low;
   assign raw[SY_FBLOW] = fb_below_tenth;
   assign raw[SY_OV]    = ov_fault;
   assign raw[SY_UV]    = uv_fault;
   assign raw[SY_OT]    = ot_fault;
   assign raw[SY_ZC]    = zero_cross;

   for (genvar i = 0; i < SY_N; i++) begin : g_sync
      always_ff @(posedge clock) begin
         if (rst) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
         end
      end
   end

   // role detection
   logic [1:0] role_cnt_q, role_cnt_d;
   logic       role_done_q, role_done_d;
   logic       master_q, master_d;
   always_comb begin
      role_cnt_d  = role_cnt_q;
      role_done_d = role_done_q;
      master_d    = master_q;
      if (!role_done_q) begin
         if (role_cnt_q == 2'(ROLE_WAIT)) begin
            role_done_d = 1'b1;
            master_d    = s2_q[SY_TOKEN]; // see R01
         end else begin
            role_cnt_d = role_cnt_q + 2'h1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         role_cnt_q  <= 2'h0;
         role_done_q <= 1'b0;
         master_q    <= 1'b0;
      end else begin
         role_cnt_q  <= role_cnt_d;
         role_done_q <= role_done_d;
         master_q    <= master_d;
      end
   end

   // command registers
   mph_word_t regs_q [NREG];
   mph_word_t regs_d [NREG];
   logic      rsp_valid_q, rsp_valid_d;
   logic      rsp_nack_q, rsp_nack_d;
   mph_word_t rsp_data_q, rsp_data_d;
   logic [3:0] dec;
   always_comb begin
      dec         = reg_idx(cmd_code);
      regs_d      = regs_q;
      rsp_valid_d = cmd_valid;
      rsp_nack_d  = 1'b0;
      rsp_data_d  = 16'h0000;
      if (cmd_valid) begin
         if (!dec[3]) begin
            rsp_nack_d = 1'b1;
         end else if (cmd_write) begin
            regs_d[dec[2:0]] = cmd_wdata; // see R02, R22
         end else if (!master_q) begin
            rsp_nack_d = 1'b1; // see R02
         end else begin
            rsp_data_d = regs_q[dec[2:0]];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int k = 0; k < NREG; k++) begin
            regs_q[k] <= REG_RST;
         end
         rsp_valid_q <= 1'b0;
         rsp_nack_q  <= 1'b0;
         rsp_data_q  <= 16'h0000;
      end else begin
         regs_q      <= regs_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_nack_q  <= rsp_nack_d;
         rsp_data_q  <= rsp_data_d;
      end
   end

   logic ccm_sel, shed_bit, shed_src, disch_en, rrst_sel;
   assign ccm_sel  = regs_q[IX_MODE][CCM_BIT];
   assign shed_bit = regs_q[IX_SHED][SHED_BIT];
   assign shed_src = regs_q[IX_SHED][SHED_SRC_BIT];
   assign disch_en = regs_q[IX_DISCH][DISCH_BIT]; // see R21
   assign rrst_sel = regs_q[IX_RRST][RRST_BIT];

   // phase shedding
   logic phase_on;
   assign phase_on = master_q |
      !(shed_src ? !s2_q[SY_SHED] : shed_bit); // see R14, R15, R16

   // sequencing state machine
   mph_state_e st_q, st_d;
   logic [19:0] ss_cnt_q, ss_cnt_d;
   logic [2:0]  bst_cnt_q, bst_cnt_d;
   logic        go, active, first;
   assign go     = s2_q[SY_EN] & op_on;
   assign active = (st_q == ST_SOFT) | (st_q == ST_RUN);
   always_comb begin
      st_d      = st_q;
      ss_cnt_d  = ss_cnt_q;
      bst_cnt_d = (bst_cnt_q != 3'h0) ? bst_cnt_q - 3'h1 : 3'h0;
      first     = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (go && role_done_q) begin
               st_d = master_q ? ST_PREBIAS : ST_RUN; // see R09
            end
         end
         ST_PREBIAS: begin
            if (!go) begin
               st_d = ST_IDLE;
            end else if (s2_q[SY_REF]) begin
               st_d     = ST_SOFT; // see R18
               ss_cnt_d = 20'h00000;
               first    = 1'b1; // see R09
            end else if (s2_q[SY_BST] && bst_cnt_q == 3'h0) begin
               bst_cnt_d = 3'(BST_PULSE_CYC); // see R19
            end
         end
         ST_SOFT: begin
            if (!go) begin
               st_d = disch_en ? ST_DISCH : ST_IDLE;
            end else if (ss_cnt_q >= ss_len(regs_q[IX_SS][SS_CODE_LSB +: 3]) - 20'h1) begin
               st_d = ST_RUN; // see R17
            end else begin
               ss_cnt_d = ss_cnt_q + 20'h1;
            end
         end
         ST_RUN: begin
            if (!go) begin
               st_d = disch_en ? ST_DISCH : ST_IDLE; // see R20
            end
         end
         ST_DISCH: begin
            if (s2_q[SY_FBLOW]) begin
               st_d = ST_IDLE; // see R20
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         st_q      <= ST_IDLE;
         ss_cnt_q  <= 20'h00000;
         bst_cnt_q <= 3'h0;
      end else begin
         st_q      <= st_d;
         ss_cnt_q  <= ss_cnt_d;
         bst_cnt_q <= bst_cnt_d;
      end
   end

   // trigger generation and token ring
   logic [1:0] gap_q, gap_d;
   logic       pend_q, pend_d;
   logic       run_q, run_d;
   logic [7:0] on_cnt_q, on_cnt_d;
   logic [1:0] tok_cnt_q, tok_cnt_d;
   logic       trig_q, trig_d;
   logic       gen, trig_evt, tok_fall, fire, cross_rise;
   assign cross_rise = s2_q[SY_CROSS] & !s3_q[SY_CROSS];
   assign tok_fall   = !s2_q[SY_TOKEN] & s3_q[SY_TOKEN];
   always_comb begin
      gen = master_q & active & (cross_rise | pend_q) &
            (gap_q >= 2'(MIN_TRIG_CYC)); // see R03, R07
      trig_d   = gen;
      trig_evt = master_q ? gen : (s2_q[SY_TRIG] & !s3_q[SY_TRIG]);
      pend_d   = master_q & active & !gen & (pend_q | cross_rise);
      gap_d    = gen ? 2'h1 : (gap_q >= 2'(MIN_TRIG_CYC)) ? gap_q : gap_q + 2'h1;
      fire     = trig_evt & run_q & active & phase_on; // see R03
      if (tok_fall || first) begin
         run_d = 1'b1; // see R05
      end else if (fire || !active) begin
         run_d = 1'b0; // see R23
      end else begin
         run_d = run_q;
      end
      if (fire) begin
         on_cnt_d  = (on_width == 8'h00) ? 8'h01 : on_width; // see R04
         tok_cnt_d = 2'(TOK_PULSE_CYC); // see R04
      end else begin
         on_cnt_d  = (on_cnt_q != 8'h00) ? on_cnt_q - 8'h01 : 8'h00; // see R06
         tok_cnt_d = (tok_cnt_q != 2'h0) ? tok_cnt_q - 2'h1 : 2'h0;
      end
      if (!active) begin
         on_cnt_d = 8'h00; // see R18, R20
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         gap_q     <= 2'(MIN_TRIG_CYC);
         pend_q    <= 1'b0;
         run_q     <= 1'b0;
         on_cnt_q  <= 8'h00;
         tok_cnt_q <= 2'h0;
         trig_q    <= 1'b0;
      end else begin
         gap_q     <= gap_d;
         pend_q    <= pend_d;
         run_q     <= run_d;
         on_cnt_q  <= on_cnt_d;
         tok_cnt_q <= tok_cnt_d;
         trig_q    <= trig_d;
      end
   end

   // switch, ramp and alert outputs
   logic hs_q, hs_d, ls_q, ls_d, dis_q, dis_d, tok_q, tok_d;
   logic rr_q, rr_d, ra_q, ra_d, pg_oe_q, pg_oe_d, sf_q, sf_d;
   always_comb begin
      dis_d   = st_d == ST_DISCH; // see R20
      hs_d    = (on_cnt_d != 8'h00) & !dis_d; // see R20
      tok_d   = tok_cnt_d != 2'h0;
      ls_d    = ((bst_cnt_d != 3'h0) |
                (active & phase_on & !hs_d & (ccm_sel | !s2_q[SY_ZC]))) & !dis_d; // see R13, R19
      rr_d    = master_q & (rrst_sel ? trig_evt : (hs_d & !hs_q)); // see R10, R12
      ra_d    = master_q & active; // see R10
      pg_oe_d = !master_q & (s2_q[SY_OV] | s2_q[SY_UV] | s2_q[SY_OT]); // see R08
      sf_d    = master_q & !s2_q[SY_PG]; // see R08
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         hs_q    <= 1'b0;
         ls_q    <= 1'b0;
         dis_q   <= 1'b0;
         tok_q   <= 1'b0;
         rr_q    <= 1'b0;
         ra_q    <= 1'b0;
         pg_oe_q <= 1'b0;
         sf_q    <= 1'b0;
      end else begin
         hs_q    <= hs_d;
         ls_q    <= ls_d;
         dis_q   <= dis_d;
         tok_q   <= tok_d;
         rr_q    <= rr_d;
         ra_q    <= ra_d;
         pg_oe_q <= pg_oe_d;
         sf_q    <= sf_d;
      end
   end

   assign token_out        = tok_q;
   assign trigger_out      = trig_q;
   assign pg_out           = 1'b0;
   assign pg_oe            = pg_oe_q;
   assign rsp_valid        = rsp_valid_q;
   assign rsp_data         = rsp_data_q;
   assign rsp_nack         = rsp_nack_q;
   assign high_side_switch = hs_q;
   assign low_side_switch  = ls_q;
   assign discharge_switch = dis_q;
   assign is_master        = master_q;
   assign slave_fault      = sf_q;
   assign ramp_reset       = rr_q;
   assign ramp_active      = ra_q;
   assign ramp_amp         = regs_q[IX_RAMP][RAMP_AMP_LSB +: 3]; // see R11
   assign ccm_mode         = ccm_sel; // see R13
   assign valley_limit     = regs_q[IX_VLIM]; // see R22

   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_fire6;
      fire && !dis_d && on_width == 8'h06;
   endsequence
   sequence s_hs6;
      high_side_switch [*6] ##1 !high_side_switch;
   endsequence

   a_trig_spacing: assert property (trigger_out |=> !trigger_out) // see R07
      else $error("triggers closer than minimum interval");
   a_slave_no_trig: assert property (!master_q |-> !trigger_out) // see R03
      else $error("slave drove trigger");
   a_fire_outputs: assert property (fire && !dis_d |=> high_side_switch && token_out) // see R04
      else $error("fire without high side and token pulse");
   a_on_width: assert property (s_fire6 |=> s_hs6) // see R06
      else $error("on pulse width wrong");
   a_run_clear: assert property (fire && !tok_fall |=> !run_q) // see R23
      else $error("run token kept after fire");
   a_token_arm: assert property (tok_fall |=> run_q) // see R05
      else $error("falling token edge did not arm run");
   a_slave_read: assert property (cmd_valid && !cmd_write && !master_q
      |=> rsp_valid && rsp_nack) // see R02
      else $error("slave answered a read");
   a_master_kept: assert property (master_q |-> phase_on) // see R16
      else $error("master phase shed");
   a_shed_pin: assert property (!master_q && shed_src && !s2_q[SY_SHED]
      |-> !phase_on) // see R15
      else $error("shedding pin ignored");
   a_prebias_off: assert property (st_q == ST_PREBIAS && $past(st_q) == ST_PREBIAS
      |-> !high_side_switch) // see R18
      else $error("high side on during pre-bias hold");
   a_bst_pulse: assert property (st_q == ST_PREBIAS && go && !s2_q[SY_REF]
      && s2_q[SY_BST] && bst_cnt_q == 3'h0 |=> low_side_switch [*5]) // see R19
      else $error("bootstrap recharge pulse wrong");
   a_disch_off: assert property (discharge_switch
      |-> !high_side_switch && !low_side_switch) // see R20
      else $error("switch on during discharge");
   a_ramp_master: assert property (!master_q |-> !ramp_reset && !ramp_active) // see R10
      else $error("slave applied ramp");
endmodule

//--- sim/mph_ring_partner.sv
module mph_ring_partner (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // token ring and trigger
   input  wire logic pull_high,
   input  wire logic pass_in,
   input  wire logic set_in,
   output logic      take_out,
   // alert line
   input  wire logic fault,
   output logic      pg_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       prev_q, prev_d;
   logic       run_q, run_d;
   logic [1:0] cnt_q, cnt_d;
   always_comb begin
      prev_d = pass_in;
      run_d  = run_q;
      cnt_d  = (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
      if (run_q && set_in) begin
         run_d = 1'b0;
         cnt_d = 2'h2;
      end
      if (prev_q && !pass_in) run_d = 1'b1;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         prev_q <= 1'b0;
         run_q  <= 1'b0;
         cnt_q  <= 2'h0;
      end else begin
         prev_q <= prev_d;
         run_q  <= run_d;
         cnt_q  <= cnt_d;
      end
   end
   assign take_out = pull_high | (cnt_q != 2'h0);
   assign pg_pull  = fault;
endmodule

//--- sim/tb_top.sv
module tb_top;
   import mph_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         SSB = 8;
   localparam logic [7:0] ONW = 8'h06;
   localparam logic [7:0] CODES [7] = '{CODE_SS, CODE_RAMP, CODE_DISCH, CODE_MODE,
                                         CODE_VLIM, CODE_SHED, CODE_RRST};
   localparam mph_word_t  VALS [7] = '{16'h0000, 16'h000A, 16'h0040, 16'h0001,
                                        16'h1234, 16'h0000, 16'h0008};
   logic       clock = 1'b0, rst = 1'b1, token_in, token_out, trigger_out;
   logic       pg_in, pg_out, pg_oe, rsp_valid, rsp_nack, is_master, slave_fault;
   logic       ramp_cross = 1'b0, ref_above_fb = 1'b0, bst_low = 1'b0;
   logic       fb_below_tenth = 1'b0, zero_cross = 1'b0, trigger_in = 1'b0;
   logic       ov_fault = 1'b0, uv_fault = 1'b0, ot_fault = 1'b0;
   logic       enable_pin = 1'b0, op_on = 1'b0, shedding_pin = 1'b0;
   logic       cmd_valid = 1'b0, cmd_write = 1'b0, pull_high = 1'b1, fault = 1'b0;
   logic       high_side_switch, low_side_switch, discharge_switch, pg_pull;
   logic       ramp_reset, ramp_active, ccm_mode;
   logic [2:0] ramp_amp;
   logic [7:0] cmd_code = 8'h00, on_width = ONW;
   mph_word_t  cmd_wdata = 16'h0000, rsp_data, valley_limit;
   int         n_errors = 0, num_checks = 0, cyc = 0, gap = 100, ntrig = 0, k, t, n0;

   assign pg_in = !((pg_oe && !pg_out) || pg_pull);

   mph_phase_sequencer #(.SS_BASE_CYC(SSB)) DUT (
      .clock, .rst, .token_in, .token_out, .trigger_in, .trigger_out,
      .pg_in, .pg_out, .pg_oe, .ramp_cross, .ref_above_fb, .bst_low,
      .fb_below_tenth, .zero_cross, .ov_fault, .uv_fault, .ot_fault, .on_width,
      .enable_pin, .op_on, .shedding_pin, .cmd_valid, .cmd_write, .cmd_code,
      .cmd_wdata, .rsp_valid, .rsp_data, .rsp_nack, .high_side_switch,
      .low_side_switch, .discharge_switch, .is_master, .slave_fault, .ramp_reset,
      .ramp_active, .ramp_amp, .ccm_mode, .valley_limit);

   mph_ring_partner RING (.clock, .rst, .pull_high, .pass_in(token_out),
      .set_in(trigger_out), .take_out(token_in), .fault, .pg_pull);

   initial begin
      forever #20 clock = ~clock;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic cmd(input logic w, input logic [7:0] c, input mph_word_t d,
                      input mph_word_t ed, input logic en);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code  <= c;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      #1;
      for (k = 0; k < 3 && rsp_valid !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      chk(16'(rsp_valid), 16'h0001, "no response");
      chk(rsp_data, ed, "response data");
      chk(16'(rsp_nack), 16'(en), "refusal flag");
      @(posedge clock);
   endtask

   // crossing, then trigger, switch and token checks; err 2 skips ramp reset
   task automatic trig(input logic ehs, input logic [1:0] err);
      ramp_cross <= 1'b1;
      repeat (2) @(posedge clock);
      ramp_cross <= 1'b0;
      k = 0;
      do begin
         @(posedge clock);
         #1;
         k++;
      end while (trigger_out !== 1'b1 && k < 10);
      chk(16'(trigger_out), 16'h0001, "no trigger");
      chk(16'(high_side_switch), 16'(ehs), "high side at trigger");
      chk(16'(token_out), 16'(ehs), "token pulse at trigger");
      if (err != 2'h2) chk(16'(ramp_reset), 16'(err[0]), "ramp reset");
      if (ehs) begin
         k = 0;
         t = 0;
         while (high_side_switch === 1'b1 && k < 300) begin
            t += int'(token_out === 1'b1);
            @(posedge clock);
            #1;
            k++;
         end
         chk(16'(k), 16'(ONW), "on width");
         chk(16'(t), 16'(TOK_PULSE_CYC), "token width");
      end
      repeat (14) @(posedge clock);
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         conclude();
      end
   end

   // trigger spacing monitor
   always @(negedge clock) begin
      if (trigger_out === 1'b1) begin
         chk(16'(gap + 1 >= MIN_TRIG_CYC), 16'h0001, "triggers too close");
         gap = 0;
         ntrig++;
      end else gap++;
   end

   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      chk(16'(is_master), 16'h0001, "master role");
      pull_high <= 1'b0;
      for (int i = 0; i < 7; i++) cmd(1'b0, CODES[i], 16'h0000, REG_RST, 1'b0);
      for (int i = 0; i < 7; i++) cmd(1'b1, CODES[i], VALS[i], 16'h0000, 1'b0);
      for (int i = 0; i < 7; i++) cmd(1'b0, CODES[i], 16'h0000, VALS[i], 1'b0);
      cmd(1'b0, 8'h62, 16'h0000, 16'h0000, 1'b1);
      cmd(1'b1, 8'hFF, 16'h5A5A, 16'h0000, 1'b1);
      chk(16'(ramp_amp), 16'h0005, "ramp amplitude");
      chk(16'(ccm_mode), 16'h0001, "mode");
      chk(valley_limit, 16'h1234, "valley limit");
      ramp_cross <= 1'b1;
      repeat (2) @(posedge clock);
      ramp_cross <= 1'b0;
      repeat (8) @(posedge clock);
      chk(16'(ntrig), 16'h0000, "trigger while idle");
      enable_pin <= 1'b1;
      op_on      <= 1'b1;
      repeat (8) @(posedge clock);
      chk(16'({high_side_switch, low_side_switch}), 16'h0000, "prebias");
      bst_low <= 1'b1;
      repeat (2) @(posedge clock);
      bst_low <= 1'b0;
      k = 0;
      repeat (15) begin
         @(posedge clock);
         #1;
         k += int'(low_side_switch === 1'b1);
      end
      chk(16'(k), 16'(BST_PULSE_CYC), "bootstrap pulse");
      @(posedge clock);
      ref_above_fb <= 1'b1;
      repeat (6) @(posedge clock);
      trig(1'b1, 2'h1);
      trig(1'b0, 2'h1);
      cmd(1'b1, CODE_RRST, 16'h0000, 16'h0000, 1'b0);
      trig(1'b1, 2'h1);
      trig(1'b0, 2'h0);
      cmd(1'b1, CODE_SHED, 16'h0003, 16'h0000, 1'b0);
      trig(1'b1, 2'h1);
      n0 = ntrig;
      repeat (3) begin
         ramp_cross <= 1'b1;
         @(posedge clock);
         ramp_cross <= 1'b0;
         @(posedge clock);
      end
      repeat (12) @(posedge clock);
      chk(16'(ntrig - n0), 16'h0003, "burst triggers");
      fault <= 1'b1;
      repeat (5) @(posedge clock);
      chk(16'(slave_fault), 16'h0001, "slave alert");
      fault      <= 1'b0;
      enable_pin <= 1'b0;
      for (k = 0; k < 12 && discharge_switch !== 1'b1; k++) @(negedge clock);
      chk(16'({discharge_switch, high_side_switch, low_side_switch}), 16'h0004,
          "discharge");
      @(posedge clock);
      fb_below_tenth <= 1'b1;
      for (k = 0; k < 12 && discharge_switch !== 1'b0; k++) @(negedge clock);
      chk(16'(discharge_switch), 16'h0000, "discharge end");
      // second start as a slave: token input low through reset
      @(posedge clock);
      rst        <= 1'b1;
      enable_pin <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      chk(16'(is_master), 16'h0000, "slave role");
      cmd(1'b0, CODE_VLIM, 16'h0000, 16'h0000, 1'b1);
      cmd(1'b1, CODE_SHED, 16'h0003, 16'h0000, 1'b0);
      ov_fault  <= 1'b1;
      pull_high <= 1'b1;
      repeat (4) @(posedge clock);
      chk(16'({pg_oe, pg_in}), 16'h0002, "slave alert drive");
      ov_fault  <= 1'b0;
      pull_high <= 1'b0;
      repeat (5) @(posedge clock);
      for (int p = 0; p < 2; p++) begin
         @(posedge clock);
         shedding_pin <= p[0];
         trigger_in   <= 1'b1;
         repeat (2) @(posedge clock);
         trigger_in <= 1'b0;
         k = 0;
         repeat (12) begin
            @(posedge clock);
            #1;
            k += int'(high_side_switch === 1'b1);
         end
         chk(16'(k), 16'(p * ONW), "slave shedding pin");
      end
      conclude();
   end
endmodule
